// [msac_pkg.sv]
// Package: constants and types of the mode segment access control block
package msac_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int VA_W        = 16;
  localparam int SEG_MAX     = 64;
  localparam int HW_N        = 16;
  localparam int RD_W        = 32;
  localparam int RA_W        = 8;
  localparam int IRQ_W       = 3;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_BOOT = 3'h0,
    MODE_TEST = 3'h1,
    MODE_FW   = 3'h2,
    MODE_SYS  = 3'h3,
    MODE_USER = 3'h4
  } msac_mode_t;

  typedef enum logic [1:0] {
    KIND_READ  = 2'h0,
    KIND_WRITE = 2'h1,
    KIND_EXEC  = 2'h2
  } msac_kind_t;

  typedef enum logic [2:0] {
    CLS_MMU_CFG  = 3'h0,
    CLS_SYS_MGT  = 3'h1,
    CLS_FIREWALL = 3'h2,
    CLS_FW_INT   = 3'h3,
    CLS_TEST     = 3'h4,
    CLS_HW_COMP  = 3'h5,
    CLS_CPU_GEN  = 3'h6
  } msac_cls_t;

  typedef enum logic [1:0] {
    LD_IDLE = 2'h0,
    LD_REQ  = 2'h1,
    LD_WAIT = 2'h2
  } msac_ld_t;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [RA_W-1:0] OFF_MODE      = 8'h00;
  localparam logic [RA_W-1:0] OFF_SEG_PTR   = 8'h04;
  localparam logic [RA_W-1:0] OFF_SEG_COUNT = 8'h08;
  localparam logic [RA_W-1:0] OFF_CTRL      = 8'h0c;
  localparam logic [RA_W-1:0] OFF_STATUS    = 8'h10;
  localparam logic [RA_W-1:0] OFF_FW_HW_LO  = 8'h20;
  localparam logic [RA_W-1:0] OFF_FW_HW_HI  = 8'h24;
  localparam logic [RA_W-1:0] OFF_XB_LO     = 8'h28;
  localparam logic [RA_W-1:0] OFF_XB_HI     = 8'h2c;
  localparam logic [RA_W-1:0] OFF_XS_LO     = 8'h30;
  localparam logic [RA_W-1:0] OFF_XS_HI     = 8'h34;
  localparam logic [RA_W-1:0] OFF_IRQ_STAT  = 8'h38;
  localparam logic [RA_W-1:0] OFF_IRQ_MASK  = 8'h3c;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_LOAD_BIT = 0;
  localparam int IRQ_DENY      = 0;
  localparam int IRQ_SFR       = 1;
  localparam int IRQ_LOAD      = 2;
  localparam logic [1:0] ENTRY_LAST_WORD = 2'h2;
  localparam msac_mode_t MODE_RST = MODE_BOOT;
  localparam logic [VA_W-1:0] SEG_PTR_RST = 16'h0000;
  localparam logic [HW_N-1:0] FW_HW_RST   = 16'h0000;
  localparam logic [VA_W-1:0] XWIN_RST    = 16'h0000;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  // ----------------------------------------------------------------
  // Physical memory map
  // ----------------------------------------------------------------
  localparam logic [VA_W-1:0] ROM_TEST_END = 16'h1000;
  localparam logic [VA_W-1:0] EE_BASE      = 16'h4000;
  localparam logic [VA_W-1:0] EE_FW_END    = 16'h5000;
  localparam logic [VA_W-1:0] RAM_BASE     = 16'hc000;
  localparam logic [VA_W-1:0] RAM_FW_END   = 16'hc400;

endpackage

// [msac_top.sv]
// Module: mode and segment based access control with address translation
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none

module msac_top
  import msac_pkg::*;
#(
  parameter int SEG_N = SEG_MAX
) (
  // Clock and reset
  input  wire  logic                  sys_clk,
  input  wire  logic                  sys_rst,
  // Register port
  input  wire  logic [RA_W-1:0]       reg_addr,
  input  wire  logic [RD_W-1:0]       reg_wdata,
  input  wire  logic                  reg_wr,
  input  wire  logic                  reg_rd,
  output logic       [RD_W-1:0]       reg_rdata,
  output logic                        reg_exc,
  // Access request from CPU or copy machine
  input  wire  logic                  acc_req,
  input  wire  logic                  acc_dma,
  input  wire  logic [1:0]            acc_kind,
  input  wire  logic [VA_W-1:0]       acc_vaddr,
  input  wire  logic [VA_W-1:0]       acc_pc,
  input  wire  logic                  acc_sfr,
  input  wire  logic [2:0]            acc_sfr_cls,
  input  wire  logic [3:0]            acc_hw_idx,
  // Access answer
  output logic                        acc_done,
  output logic                        acc_grant,
  output logic                        acc_exc,
  output msac_mode_t                  acc_mode,
  output logic                        mem_en,
  output logic                        mem_we,
  output logic       [VA_W-1:0]       mem_paddr,
  output logic                        sfr_en,
  output logic                        cpu_bank_user,
  // Segment table fetch port
  output logic                        tbl_rd,
  output logic       [VA_W-1:0]       tbl_addr,
  input  wire  logic [RD_W-1:0]       tbl_rdata,
  // Coprocessor operand RAM path
  input  wire  logic                  cop_req,
  input  wire  logic                  cop_we,
  input  wire  logic [VA_W-1:0]       cop_addr,
  output logic                        cop_ram_en,
  output logic                        cop_ram_we,
  output logic       [VA_W-1:0]       cop_ram_addr,
  // Interrupt
  output logic                        irq
);

  localparam int IDX_W = $clog2(SEG_N);
  localparam int CNT_W = $clog2(SEG_N + 1);

  typedef struct packed {
    msac_mode_t       mode;
    logic [VA_W-1:0]  seg_ptr;
    logic [CNT_W-1:0] seg_count;
    logic [HW_N-1:0]  fw_hw;
    logic [VA_W-1:0]  xbase;
    logic [VA_W-1:0]  xsize;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [RD_W-1:0]  rdata;
    logic             reg_exc;
    msac_ld_t         ld_state;
    logic [IDX_W-1:0] ld_idx;
    logic [1:0]       ld_word;
    logic [VA_W-1:0]  ld_addr;
    logic [RD_W-1:0]  ld_w0;
    logic [RD_W-1:0]  ld_w1;
    logic [CNT_W-1:0] valid_cnt;
    logic             done;
    logic             grant;
    logic             exc;
    logic             mem_en;
    logic             mem_we;
    logic             sfr_en;
    logic [VA_W-1:0]  paddr;
    msac_mode_t       tag;
    logic             cop_en;
    logic             cop_we;
    logic [VA_W-1:0]  cop_addr;
  } msac_state_t;

  msac_state_t s_r;
  msac_state_t s_nxt;

  // ----------------------------------------------------------------
  // Cached segment table
  // ----------------------------------------------------------------
  logic [VA_W-1:0] tbl_first [SEG_N];
  logic [VA_W-1:0] tbl_last  [SEG_N];
  logic [2:0]      tbl_rwx   [SEG_N];
  logic [VA_W-1:0] tbl_off   [SEG_N];
  logic [HW_N-1:0] tbl_hw    [SEG_N];
  logic            tbl_we;

  assign tbl_we = (s_r.ld_state == LD_WAIT) && (s_r.ld_word == ENTRY_LAST_WORD);

  // Entry lands only after all three words are in; no reset, gated by valid_cnt
  always_ff @(posedge sys_clk) begin
    if (tbl_we) begin
      tbl_first[s_r.ld_idx] <= s_r.ld_w0[31:16];
      tbl_last[s_r.ld_idx]  <= s_r.ld_w0[15:0];
      tbl_rwx[s_r.ld_idx]   <= s_r.ld_w1[18:16];
      tbl_off[s_r.ld_idx]   <= s_r.ld_w1[15:0];
      tbl_hw[s_r.ld_idx]    <= tbl_rdata[HW_N-1:0];
    end
  end

  // Lowest matching index wins; overlap is a firmware fault, not checked here
  function automatic logic [IDX_W:0] seg_find(input logic [VA_W-1:0] a);
    logic [IDX_W:0] r;
    r = '0;
    for (int i = SEG_N - 1; i >= 0; i--) begin
      if (CNT_W'(i) < s_r.valid_cnt && tbl_rwx[i] != 3'h0 &&
          a >= tbl_first[i] && a <= tbl_last[i]) begin
        r = {1'b1, IDX_W'(i)};
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Access rights
  // ----------------------------------------------------------------
  function automatic logic mem_ok(input msac_mode_t m, input logic [VA_W-1:0] p,
                                  input logic [1:0] k, input logic dma, input logic hit,
                                  input logic [2:0] rwx, input logic in_win);
    logic t_rom, a_rom, f_ee, a_ee, f_ram, a_ram, legal, r;
    t_rom = p < ROM_TEST_END;
    a_rom = p >= ROM_TEST_END && p < EE_BASE;
    f_ee  = p >= EE_BASE && p < EE_FW_END;
    a_ee  = p >= EE_FW_END && p < RAM_BASE;
    f_ram = p >= RAM_BASE && p < RAM_FW_END;
    a_ram = p >= RAM_FW_END;
    // ROM is never written, RAM never executed, the copy machine never executes
    legal = !((t_rom || a_rom) && k == KIND_WRITE) && !((f_ram || a_ram) && k == KIND_EXEC)
            && !(dma && k == KIND_EXEC) && k != 2'h3;
    case (m)
      MODE_BOOT: r = t_rom || f_ee || f_ram;
      MODE_TEST: r = 1'b1;
      MODE_FW:   r = t_rom || f_ee || (a_ee && k != KIND_EXEC) || f_ram
                     || (a_ram && in_win);
      MODE_SYS:  r = a_rom || a_ee || a_ram;
      MODE_USER: r = hit && rwx[k] && (a_rom || a_ee || a_ram);
      default:   r = 1'b0;
    endcase
    return r && legal;
  endfunction

  function automatic logic sfr_ok(input msac_mode_t m, input logic [2:0] c, input logic wr,
                                  input logic fw_bit, input logic user_bit);
    logic r;
    case (c)
      CLS_MMU_CFG, CLS_SYS_MGT: r = m == MODE_BOOT || m == MODE_TEST || m == MODE_SYS;
      CLS_FIREWALL: r = wr ? m == MODE_BOOT : (m == MODE_BOOT || m == MODE_FW);
      CLS_FW_INT:   r = m == MODE_BOOT || m == MODE_FW;
      CLS_TEST:     r = m == MODE_TEST;
      CLS_HW_COMP: begin
        case (m)
          MODE_FW:   r = fw_bit;
          MODE_USER: r = user_bit;
          default:   r = 1'b1;
        endcase
      end
      CLS_CPU_GEN:  r = 1'b1;
      default:      r = 1'b0;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Per-access decode
  // ----------------------------------------------------------------
  logic [IDX_W:0]  find_v;
  logic [IDX_W:0]  find_pc;
  logic [VA_W-1:0] paddr_v;
  logic            in_win;
  logic            ok_mem;
  logic            ok_sfr;

  // The search reads the cached table and entry count; a plain assign would miss their changes
  always_comb begin
    find_v  = seg_find(acc_vaddr);
    find_pc = seg_find(acc_pc);
  end
  assign paddr_v = find_v[IDX_W] ? acc_vaddr + tbl_off[find_v[IDX_W-1:0]] : acc_vaddr;
  assign in_win  = paddr_v >= s_r.xbase &&
                   {1'b0, paddr_v} < ({1'b0, s_r.xbase} + {1'b0, s_r.xsize});
  assign ok_mem  = mem_ok(s_r.mode, paddr_v, acc_kind, acc_dma, find_v[IDX_W],
                          tbl_rwx[find_v[IDX_W-1:0]], in_win);
  // Copy machine never reaches registers; exec of a register is meaningless
  assign ok_sfr  = !acc_dma && acc_kind != KIND_EXEC &&
                   sfr_ok(s_r.mode, acc_sfr_cls, acc_kind == KIND_WRITE, s_r.fw_hw[acc_hw_idx],
                          find_pc[IDX_W] && tbl_hw[find_pc[IDX_W-1:0]][acc_hw_idx]);

  // ----------------------------------------------------------------
  // Register port rights
  // ----------------------------------------------------------------
  logic reg_fw;
  logic reg_map;
  logic reg_ok;

  assign reg_fw  = reg_addr inside {OFF_FW_HW_LO, OFF_FW_HW_HI, OFF_XB_LO, OFF_XB_HI,
                                    OFF_XS_LO, OFF_XS_HI};
  assign reg_map = reg_fw || reg_addr inside {OFF_MODE, OFF_SEG_PTR, OFF_SEG_COUNT, OFF_CTRL,
                                              OFF_STATUS, OFF_IRQ_STAT, OFF_IRQ_MASK};
  assign reg_ok  = !reg_map ||
                   (reg_addr == OFF_MODE ? (!reg_wr || s_r.mode != MODE_USER) :
                    sfr_ok(s_r.mode, reg_fw ? CLS_FIREWALL : CLS_MMU_CFG, reg_wr,
                           1'b0, 1'b0));

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [IRQ_W-1:0] set_v;
    logic             go_v;
    set_v = '0;
    go_v  = 1'b0;
    s_nxt = s_r;
    s_nxt.rdata   = '0;
    s_nxt.reg_exc = 1'b0;
    s_nxt.done    = 1'b0;
    s_nxt.exc     = 1'b0;
    s_nxt.mem_en  = 1'b0;
    s_nxt.mem_we  = 1'b0;
    s_nxt.sfr_en  = 1'b0;
    s_nxt.cop_en  = 1'b0;
    s_nxt.cop_we  = 1'b0;

    // Register port
    if ((reg_wr || reg_rd) && !reg_ok) begin
      s_nxt.reg_exc = 1'b1;
      set_v[IRQ_SFR] = 1'b1;
    end else if (reg_wr) begin
      case (reg_addr)
        OFF_MODE: begin
          if (reg_wdata[2:0] <= MODE_USER) begin
            s_nxt.mode = msac_mode_t'(reg_wdata[2:0]);
          end
        end
        OFF_SEG_PTR:   s_nxt.seg_ptr = reg_wdata[VA_W-1:0];
        OFF_SEG_COUNT: s_nxt.seg_count = (reg_wdata > RD_W'(SEG_N)) ? CNT_W'(SEG_N) :
                                         reg_wdata[CNT_W-1:0];
        OFF_CTRL:      go_v = reg_wdata[CTRL_LOAD_BIT];
        OFF_FW_HW_LO:  s_nxt.fw_hw[7:0] = reg_wdata[7:0];
        OFF_FW_HW_HI:  s_nxt.fw_hw[15:8] = reg_wdata[7:0];
        OFF_XB_LO:     s_nxt.xbase[7:0] = reg_wdata[7:0];
        OFF_XB_HI:     s_nxt.xbase[15:8] = reg_wdata[7:0];
        OFF_XS_LO:     s_nxt.xsize[7:0] = reg_wdata[7:0];
        OFF_XS_HI:     s_nxt.xsize[15:8] = reg_wdata[7:0];
        OFF_IRQ_MASK:  s_nxt.irq_mask = reg_wdata[IRQ_W-1:0];
        default: ;
      endcase
    end else if (reg_rd) begin
      case (reg_addr)
        OFF_MODE:      s_nxt.rdata = RD_W'(s_r.mode);
        OFF_SEG_PTR:   s_nxt.rdata = RD_W'(s_r.seg_ptr);
        OFF_SEG_COUNT: s_nxt.rdata = RD_W'(s_r.seg_count);
        OFF_STATUS:    s_nxt.rdata = {16'h0000, 8'(s_r.valid_cnt), 7'h00,
                                      s_r.ld_state != LD_IDLE};
        OFF_FW_HW_LO:  s_nxt.rdata = RD_W'(s_r.fw_hw[7:0]);
        OFF_FW_HW_HI:  s_nxt.rdata = RD_W'(s_r.fw_hw[15:8]);
        OFF_XB_LO:     s_nxt.rdata = RD_W'(s_r.xbase[7:0]);
        OFF_XB_HI:     s_nxt.rdata = RD_W'(s_r.xbase[15:8]);
        OFF_XS_LO:     s_nxt.rdata = RD_W'(s_r.xsize[7:0]);
        OFF_XS_HI:     s_nxt.rdata = RD_W'(s_r.xsize[15:8]);
        OFF_IRQ_STAT:  s_nxt.rdata = RD_W'(s_r.irq_stat);
        OFF_IRQ_MASK:  s_nxt.rdata = RD_W'(s_r.irq_mask);
        default:       s_nxt.rdata = '0;
      endcase
    end

    // Table loader: a restart drops every cached entry at once
    case (s_r.ld_state)
      LD_IDLE: ;
      LD_REQ:  s_nxt.ld_state = LD_WAIT;
      LD_WAIT: begin
        s_nxt.ld_addr = s_r.ld_addr + 16'h0001;
        s_nxt.ld_word = s_r.ld_word + 2'h1;
        s_nxt.ld_state = LD_REQ;
        if (s_r.ld_word == 2'h0) begin
          s_nxt.ld_w0 = tbl_rdata;
        end else if (s_r.ld_word == 2'h1) begin
          s_nxt.ld_w1 = tbl_rdata;
        end else begin
          s_nxt.ld_word = 2'h0;
          s_nxt.ld_idx = s_r.ld_idx + IDX_W'(1);
          s_nxt.valid_cnt = s_r.valid_cnt + CNT_W'(1);
          if (s_r.valid_cnt + CNT_W'(1) == s_r.seg_count) begin
            s_nxt.ld_state = LD_IDLE;
            set_v[IRQ_LOAD] = 1'b1;
          end
        end
      end
      default: s_nxt.ld_state = LD_IDLE;
    endcase
    if (go_v) begin
      s_nxt.ld_addr = s_r.seg_ptr;
      s_nxt.ld_idx = '0;
      s_nxt.ld_word = 2'h0;
      s_nxt.valid_cnt = '0;
      s_nxt.ld_state = (s_r.seg_count == '0) ? LD_IDLE : LD_REQ;
      set_v[IRQ_LOAD] = s_r.seg_count == '0;
    end

    // Access check happens here; memory strobes follow only on grant
    if (acc_req) begin
      s_nxt.done = 1'b1;
      s_nxt.tag = s_r.mode;
      if (acc_sfr) begin
        s_nxt.grant = ok_sfr;
        s_nxt.sfr_en = ok_sfr;
        s_nxt.exc = !ok_sfr;
        s_nxt.mem_we = 1'b0;
        s_nxt.paddr = acc_vaddr;
        set_v[IRQ_SFR] = set_v[IRQ_SFR] | !ok_sfr;
      end else begin
        s_nxt.grant = ok_mem;
        s_nxt.mem_en = ok_mem;
        s_nxt.mem_we = ok_mem && acc_kind == KIND_WRITE;
        s_nxt.paddr = paddr_v;
        set_v[IRQ_DENY] = !ok_mem;
      end
    end

    // Own operand path, outside translation and segment checks
    if (cop_req) begin
      s_nxt.cop_en = 1'b1;
      s_nxt.cop_we = cop_we;
      s_nxt.cop_addr = cop_addr;
    end

    // Read clears, a new event in the same cycle survives
    s_nxt.irq_stat = ((reg_rd && reg_ok && reg_addr == OFF_IRQ_STAT) ? '0 : s_r.irq_stat)
                     | set_v;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.mode <= MODE_RST;
      s_r.tag <= MODE_RST;
      s_r.seg_ptr <= SEG_PTR_RST;
      s_r.fw_hw <= FW_HW_RST;
      s_r.xbase <= XWIN_RST;
      s_r.xsize <= XWIN_RST;
      s_r.irq_mask <= IRQ_MASK_RST;
      s_r.ld_state <= LD_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata     = s_r.rdata;
  assign reg_exc       = s_r.reg_exc;
  assign acc_done      = s_r.done;
  assign acc_grant     = s_r.grant;
  assign acc_exc       = s_r.exc;
  assign acc_mode      = s_r.tag;
  assign mem_en        = s_r.mem_en;
  assign mem_we        = s_r.mem_we;
  assign mem_paddr     = s_r.paddr;
  assign sfr_en        = s_r.sfr_en;
  assign cpu_bank_user = s_r.mode == MODE_USER;
  assign tbl_rd        = s_r.ld_state == LD_REQ;
  assign tbl_addr      = s_r.ld_addr;
  assign cop_ram_en    = s_r.cop_en;
  assign cop_ram_we    = s_r.cop_we;
  assign cop_ram_addr  = s_r.cop_addr;
  assign irq           = |(s_r.irq_stat & s_r.irq_mask);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence load_start_s;
    reg_wr && reg_ok && reg_addr == OFF_CTRL && reg_wdata[CTRL_LOAD_BIT] && s_r.seg_count != '0;
  endsequence
  sequence first_fetch_s;
    tbl_rd && tbl_addr == $past(s_r.seg_ptr) ##1 !tbl_rd;
  endsequence

  user_nohit_deny_a: assert property (
    acc_req && !acc_sfr && s_r.mode == MODE_USER && !find_v[IDX_W] |=> acc_done && !mem_en
  ) else $error("user access outside segments reached memory");
  mem_after_grant_a: assert property (
    mem_en |-> acc_done && acc_grant && $past(acc_req)
  ) else $error("memory strobe without granted check");
  disabled_seg_a: assert property (
    find_v[IDX_W] |-> tbl_rwx[find_v[IDX_W-1:0]] != 3'h0
  ) else $error("disabled segment matched");
  fw_boot_only_a: assert property (
    reg_wr && reg_fw && s_r.mode != MODE_BOOT |=> reg_exc && $stable(s_r.fw_hw)
  ) else $error("firewall written outside boot mode");
  sfr_refuse_exc_a: assert property (
    acc_req && acc_sfr && !ok_sfr |=> acc_exc && !sfr_en ##1 !acc_exc || acc_done
  ) else $error("refused register access without exception");
  user_hw_block_a: assert property (
    acc_req && acc_sfr && acc_sfr_cls == CLS_HW_COMP && s_r.mode == MODE_USER
    && !find_pc[IDX_W] |=> !acc_grant
  ) else $error("user reached hardware register without right");
  table_fetch_a: assert property (
    load_start_s |=> first_fetch_s
  ) else $error("table fetch not started at pointer");
  mode_tag_a: assert property (
    acc_req |=> acc_mode == $past(s_r.mode) && acc_done
  ) else $error("access not tagged with mode");
  dma_no_exec_a: assert property (
    acc_req && acc_dma && acc_kind == KIND_EXEC |=> !acc_grant && !mem_en
  ) else $error("copy machine execute granted");
  translate_a: assert property (
    acc_req && !acc_sfr && find_v[IDX_W] |=>
      mem_paddr == $past(acc_vaddr) + $past(tbl_off[find_v[IDX_W-1:0]])
  ) else $error("translated address wrong");

endmodule

`default_nettype wire

// [msac_tbl_mem.sv]
// Partner model: memory that holds the segment table
`timescale 1ns/100ps
`default_nettype none
module msac_tbl_mem
  import msac_pkg::*;
(
  // Clock
  input  wire logic            sys_clk,
  // Table fetch port
  input  wire logic            tbl_rd,
  input  wire logic [VA_W-1:0] tbl_addr,
  output logic      [RD_W-1:0] tbl_rdata
);
  // ----------------------------------------------------------------
  // Table at 0x0100: read-only 0x8000-0x80ff, then a disabled entry
  // ----------------------------------------------------------------
  logic [RD_W-1:0] word_r [6] = '{32'h800080ff, 32'h00011000, 32'h00000008,
                                  32'h900090ff, 32'h00000000, 32'h0000ffff};
  logic [RD_W-1:0] data_r;
  // Toggles between answers so a stale word never passes for data
  always_ff @(posedge sys_clk) begin
    if (tbl_rd) begin
      data_r <= word_r[tbl_addr[2:0]];
    end else begin
      data_r <= ~data_r;
    end
  end
  assign tbl_rdata = data_r;
endmodule
`default_nettype wire

// [msac_top_bench.sv]
// Testbench: scenario sequence for the mode segment access control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module msac_top_bench;
  import msac_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic            sys_clk = 1'h0, sys_rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
  logic            acc_req = 1'h0, acc_dma = 1'h0, acc_sfr = 1'h0;
  logic [1:0]      acc_kind = 2'h0;
  logic [2:0]      acc_sfr_cls = 3'h5;
  logic [3:0]      acc_hw_idx = 4'h0;
  logic [RA_W-1:0] reg_addr = 8'h0;
  logic [RD_W-1:0] reg_wdata = 32'h0, reg_rdata, tbl_rdata, v;
  logic [VA_W-1:0] acc_vaddr = 16'h0, acc_pc = 16'h0, mem_paddr, tbl_addr;
  logic            reg_exc, acc_done, acc_grant, acc_exc, mem_en, mem_we, sfr_en;
  logic            cpu_bank_user, tbl_rd, irq;
  logic            cop_req = 1'h0, cop_we = 1'h0, cop_ram_en, cop_ram_we;
  logic [VA_W-1:0] cop_addr = 16'h0, cop_ram_addr;
  msac_mode_t      acc_mode;
  int              n_errors = 0, total_checks = 0;
  always #5 sys_clk = ~sys_clk;
  msac_top i_msac_top (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .reg_exc, .acc_req, .acc_dma, .acc_kind, .acc_vaddr, .acc_pc, .acc_sfr,
    .acc_sfr_cls, .acc_hw_idx, .acc_done, .acc_grant, .acc_exc, .acc_mode, .mem_en,
    .mem_we, .mem_paddr, .sfr_en, .cpu_bank_user, .tbl_rd, .tbl_addr, .tbl_rdata,
    .cop_req, .cop_we, .cop_addr, .cop_ram_en, .cop_ram_we,
    .cop_ram_addr, .irq);
  msac_tbl_mem i_msac_tbl_mem (.sys_clk, .tbl_rd, .tbl_addr, .tbl_rdata);
  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    @(posedge sys_clk);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
    #1 `CHK(reg_exc, e)
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask
  task automatic acc(input logic dm, input logic [1:0] k, input logic [15:0] va, pc,
                     input logic s, input logic [3:0] i, input logic g, x);
    @(posedge sys_clk);
    acc_req    <= 1'h1;
    acc_dma    <= dm;
    acc_kind   <= k;
    acc_vaddr  <= va;
    acc_pc     <= pc;
    acc_sfr    <= s;
    acc_hw_idx <= i;
    @(posedge sys_clk);
    acc_req <= 1'h0;
    #1 `CHK(acc_done, 1'h1)
    `CHK(acc_grant, g)
    `CHK(mem_en, g & ~s)
    `CHK(acc_exc, x)
    `CHK(sfr_en, g & s)
    `CHK(mem_we, g & ~s & (k == KIND_WRITE))
  endtask
  task automatic sfr_cls(input logic [2:0] c, input logic g);
    @(posedge sys_clk);
    acc_sfr_cls <= c;
    acc(0, KIND_READ, 16'h2, 16'h8000, 1, 4'h0, g, ~g);
    @(posedge sys_clk);
    acc_sfr_cls <= CLS_HW_COMP;
  endtask
  task automatic cop_path();
    @(posedge sys_clk);
    cop_req  <= 1'h1;
    cop_we   <= 1'h1;
    cop_addr <= 16'h0123;
    @(posedge sys_clk);
    cop_req <= 1'h0;
    #1 `CHK(cop_ram_en, 1'h1)
    `CHK(cop_ram_we, 1'h1)
    `CHK(cop_ram_addr, 16'h0123)
    @(posedge sys_clk);
    #1 `CHK(cop_ram_en, 1'h0)
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'h0;
    rd(OFF_MODE, v);
    `CHK(v, 32'h0)
    rd(8'h80, v);
    `CHK(v, 32'h0)
    acc(0, KIND_WRITE, 16'h4010, 16'h4000, 0, 0, 1, 0);
    `CHK(mem_paddr, 16'h4010)
    acc(0, KIND_READ, 16'h8000, 16'h4000, 0, 0, 0, 0);
    wr(OFF_MODE, 32'h1, 0);
    acc(0, KIND_WRITE, 16'h8000, 16'h4000, 0, 0, 1, 0);
    acc(0, KIND_WRITE, 16'h0100, 16'h4000, 0, 0, 0, 0);
    wr(OFF_MODE, 32'h0, 0);
    wr(OFF_MODE, 32'h7, 0);
    rd(OFF_MODE, v);
    `CHK(v, 32'h0)
    wr(OFF_FW_HW_LO, 32'h4, 0);
    wr(OFF_XB_HI, 32'hd0, 0);
    wr(OFF_XS_HI, 32'h1, 0);
    wr(OFF_SEG_PTR, 32'h100, 0);
    wr(OFF_SEG_COUNT, 32'h2, 0);
    wr(OFF_CTRL, 32'h1, 0);
    v = 32'h1;
    for (int n = 0; v[0] !== 1'h0; n++) begin
      if (n == 50) begin
        n_errors++;
        end_of_test();
      end
      rd(OFF_STATUS, v);
    end
    `CHK(v[15:8], 8'h2)
    wr(OFF_MODE, 32'h2, 0);
    acc(0, KIND_READ, 16'hd010, 16'h4000, 0, 0, 1, 0);
    acc(0, KIND_READ, 16'hd100, 16'h4000, 0, 0, 0, 0);
    acc(0, KIND_READ, 16'h2, 16'h4000, 1, 4'h2, 1, 0);
    acc(0, KIND_READ, 16'h2, 16'h4000, 1, 4'h1, 0, 1);
    wr(OFF_MODE, 32'h3, 0);
    `CHK(cpu_bank_user, 1'h0)
    `CHK(irq, 1'h0)
    wr(OFF_IRQ_MASK, 32'h1, 0);
    `CHK(irq, 1'h1)
    rd(OFF_IRQ_STAT, v);
    `CHK(v, 32'h7)
    `CHK(irq, 1'h0)
    acc(0, KIND_READ, 16'h4010, 16'h8000, 0, 0, 0, 0);
    `CHK(irq, 1'h1)
    wr(OFF_MODE, 32'h4, 0);
    `CHK(cpu_bank_user, 1'h1)
    acc(0, KIND_READ, 16'h8010, 16'h8000, 0, 0, 1, 0);
    `CHK(mem_paddr, 16'h9010)
    `CHK(acc_mode, MODE_USER)
    acc(0, KIND_WRITE, 16'h8010, 16'h8000, 0, 0, 0, 0);
    acc(0, KIND_READ, 16'h9010, 16'h8000, 0, 0, 0, 0);
    acc(1, KIND_READ, 16'h8010, 16'h8000, 0, 0, 1, 0);
    acc(1, KIND_WRITE, 16'h8010, 16'h8000, 0, 0, 0, 0);
    acc(0, KIND_READ, 16'h2, 16'h8000, 1, 4'h3, 1, 0);
    acc(0, KIND_READ, 16'h2, 16'h8000, 1, 4'h4, 0, 1);
    acc(1, KIND_READ, 16'h2, 16'h8000, 1, 4'h3, 0, 1);
    sfr_cls(CLS_CPU_GEN, 1'h1);
    sfr_cls(CLS_MMU_CFG, 1'h0);
    sfr_cls(CLS_TEST, 1'h0);
    cop_path();
    wr(OFF_FW_HW_LO, 32'h0, 1);
    wr(OFF_MODE, 32'h3, 1);
    end_of_test();
  end
endmodule
`default_nettype wire
